// file: trx_exec.sv
/*
 * Execution unit for register transfers, RAM pointer updates and
 * RAM-to-register transfers of a 4-bit core, with its own nibble RAM.
 * Assumes one decoded operation per cycle from the sequencer on the same
 * clock, and that the sequencer drops the instruction after a skip pulse.
 */
module trx_exec
    import trx_pkg::*;
#(
    parameter int RAM_DEPTH = 2 ** TRX_RAM_AW
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire trx_instr_type instr,
    input wire logic [2:0] stack_pointer,
    output logic [3:0] accOut,
    output logic [3:0] accBOut,
    output logic [7:0] pairOut,
    output logic [2:0] pageOut,
    output logic [1:0] bankOut,
    output logic [3:0] filePtrOut,
    output logic [3:0] digitPtrOut,
    output logic skipNextOut
);

    trx_state_type stateReg;
    trx_state_type stateNext;
    logic [3:0] ramMem [RAM_DEPTH];
    logic [TRX_RAM_AW-1:0] ramPointer;
    logic [3:0] addressedRamNibble;
    logic ramWrEn;

    // Steps the digit pointer and reports whether it wrapped.
    function automatic logic [4:0] stepDigit(input logic [3:0] d, input logic up);
        logic [3:0] res;
        res = up ? 4'(d + 4'h1) : 4'(d - 4'h1);
        return {res == (up ? TRX_DIGIT_WRAP_UP : TRX_DIGIT_WRAP_DN), res};
    endfunction

    // Classifies the operations that exchange with or write the RAM.
    function automatic logic writesRam(input trx_op_type op);
        return op == TRX_OP_RAM_XCHG || op == TRX_OP_XCHG_DEC ||
            op == TRX_OP_XCHG_INC || op == TRX_OP_RAM_WRITE;
    endfunction

    assign ramPointer = {stateReg.bank, stateReg.filePtr, stateReg.digitPtr};
    assign addressedRamNibble = ramMem[ramPointer];
    assign ramWrEn = !sys_rst && instr.valid && writesRam(instr.op);

    always_comb begin
        logic [4:0] step;
        step = 5'h00;
        stateNext = stateReg;
        stateNext.skipNext = 1'b0;
        if (instr.valid) begin
            stateNext.prevLoadPtrs = instr.op == TRX_OP_LOAD_PTRS;
            case (instr.op)
                TRX_OP_B_TO_A: begin
                    stateNext.acc = stateReg.accB;
                end
                TRX_OP_A_TO_B: begin
                    stateNext.accB = stateReg.acc;
                end
                TRX_OP_DIGIT_TO_A: begin
                    stateNext.acc = stateReg.digitPtr;
                end
                TRX_OP_A_TO_DIGIT: begin
                    stateNext.digitPtr = stateReg.acc;
                end
                TRX_OP_PACK: begin
                    stateNext.pair = {stateReg.accB, stateReg.acc};
                end
                TRX_OP_UNPACK: begin
                    stateNext.accB = stateReg.pair[TRX_PAIR_W-1:TRX_PAIR_HI_POS];
                    stateNext.acc = stateReg.pair[TRX_PAIR_HI_POS-1:0];
                end
                TRX_OP_A_TO_PAGE: begin
                    stateNext.page = stateReg.acc[TRX_PAGE_W-1:0];
                end
                TRX_OP_PAGE_TO_A: begin
                    stateNext.acc = {1'b0, stateReg.page};
                end
                TRX_OP_BANK_TO_A: begin
                    stateNext.acc = {2'b00, stateReg.bank};
                end
                TRX_OP_FILE_TO_A: begin
                    stateNext.acc = stateReg.filePtr;
                end
                TRX_OP_SP_TO_A: begin
                    stateNext.acc = {1'b0, stack_pointer};
                end
                TRX_OP_LOAD_PTRS: begin
                    if (!stateReg.prevLoadPtrs) begin
                        stateNext.filePtr = instr.immFirst;
                        stateNext.digitPtr = instr.immSecond;
                    end
                end
                TRX_OP_LOAD_BANK: begin
                    stateNext.bank = instr.immFirst[TRX_BANK_W-1:0];
                end
                TRX_OP_INC_DIGIT, TRX_OP_DEC_DIGIT: begin
                    step = stepDigit(stateReg.digitPtr, instr.op == TRX_OP_INC_DIGIT);
                    stateNext.digitPtr = step[3:0];
                    stateNext.skipNext = step[4];
                end
                TRX_OP_RAM_READ: begin
                    stateNext.acc = addressedRamNibble;
                    stateNext.filePtr = stateReg.filePtr ^ instr.immFirst;
                end
                TRX_OP_RAM_XCHG, TRX_OP_RAM_WRITE: begin
                    if (instr.op == TRX_OP_RAM_XCHG) begin
                        stateNext.acc = addressedRamNibble;
                    end
                    stateNext.filePtr = stateReg.filePtr ^ instr.immFirst;
                end
                TRX_OP_XCHG_DEC, TRX_OP_XCHG_INC: begin
                    stateNext.acc = addressedRamNibble;
                    stateNext.filePtr = stateReg.filePtr ^ instr.immFirst;
                    step = stepDigit(stateReg.digitPtr, instr.op == TRX_OP_XCHG_INC);
                    stateNext.digitPtr = step[3:0];
                    stateNext.skipNext = step[4];
                end
                default: begin
                    stateNext.prevLoadPtrs = 1'b0;
                end
            endcase
        end
    end

    // Every operation completes in this single edge; no carry is held here.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stateReg <= '{acc: TRX_ACC_RST, accB: TRX_ACC_RST, pair: TRX_PAIR_RST,
                page: TRX_PAGE_RST, bank: TRX_BANK_RST, filePtr: TRX_NIB_RST,
                digitPtr: TRX_NIB_RST, skipNext: 1'b0, prevLoadPtrs: 1'b0};
        end else begin
            stateReg <= stateNext;
        end
    end

    // The old pointer addresses the write, before the file pointer changes.
    always_ff @(posedge clk) begin
        if (ramWrEn) begin
            ramMem[ramPointer] <= stateReg.acc;
        end
    end

    assign accOut = stateReg.acc;
    assign accBOut = stateReg.accB;
    assign pairOut = stateReg.pair;
    assign pageOut = stateReg.page;
    assign bankOut = stateReg.bank;
    assign filePtrOut = stateReg.filePtr;
    assign digitPtrOut = stateReg.digitPtr;
    assign skipNextOut = stateReg.skipNext;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    logic pastValid;
    always_ff @(posedge clk) begin
        pastValid <= !sys_rst;
    end

    a_b_to_a: assert property (pastValid && instr.valid && instr.op == TRX_OP_B_TO_A
        |=> accOut == $past(accBOut) && accBOut == $past(accBOut))
        else $error("Second accumulator not copied to accumulator.");

    a_a_to_b: assert property (pastValid && instr.valid && instr.op == TRX_OP_A_TO_B
        |=> accBOut == $past(accOut) && accOut == $past(accOut))
        else $error("Accumulator not copied to second accumulator.");

    a_digit_xfer: assert property (pastValid && instr.valid
        && instr.op == TRX_OP_DIGIT_TO_A |=> accOut == $past(digitPtrOut))
        else $error("Digit pointer not copied to accumulator.");

    a_a_to_digit: assert property (pastValid && instr.valid
        && instr.op == TRX_OP_A_TO_DIGIT |=> digitPtrOut == $past(accOut))
        else $error("Accumulator not copied to digit pointer.");

    a_pack_pair: assert property (pastValid && instr.valid && instr.op == TRX_OP_PACK
        |=> pairOut == {$past(accBOut), $past(accOut)})
        else $error("Pair register not packed correctly.");

    a_unpack_pair: assert property (pastValid && instr.valid && instr.op == TRX_OP_UNPACK
        |=> {accBOut, accOut} == $past(pairOut))
        else $error("Pair register not unpacked correctly.");

    a_page_load: assert property (pastValid && instr.valid && instr.op == TRX_OP_A_TO_PAGE
        |=> pageOut == $past(accOut[2:0]))
        else $error("Page register not loaded from accumulator.");

    a_page_read: assert property (pastValid && instr.valid && instr.op == TRX_OP_PAGE_TO_A
        |=> accOut == {1'b0, $past(pageOut)})
        else $error("Page register not placed in accumulator.");

    a_bank_read: assert property (pastValid && instr.valid && instr.op == TRX_OP_BANK_TO_A
        |=> accOut[3:2] == 2'b00 && accOut[1:0] == $past(bankOut))
        else $error("Bank pointer not placed in accumulator.");

    a_file_read: assert property (pastValid && instr.valid && instr.op == TRX_OP_FILE_TO_A
        |=> accOut == $past(filePtrOut))
        else $error("File pointer not copied to accumulator.");

    a_sp_read: assert property (pastValid && instr.valid && instr.op == TRX_OP_SP_TO_A
        |=> accOut == {1'b0, $past(stack_pointer)})
        else $error("Stack pointer not placed in accumulator.");

    a_ptr_chain: assert property (pastValid && instr.valid
        && instr.op == TRX_OP_LOAD_PTRS ##1 instr.valid && instr.op == TRX_OP_LOAD_PTRS
        |=> filePtrOut == $past(filePtrOut) && digitPtrOut == $past(digitPtrOut))
        else $error("Consecutive pointer load was not skipped.");

    a_bank_load: assert property (pastValid && instr.valid && instr.op == TRX_OP_LOAD_BANK
        |=> bankOut == $past(instr.immFirst[1:0]))
        else $error("Bank pointer not loaded from immediate.");

    a_inc_skip: assert property (pastValid && instr.valid && instr.op == TRX_OP_INC_DIGIT
        |=> digitPtrOut == 4'($past(digitPtrOut) + 4'h1)
        && skipNextOut == (digitPtrOut == 4'h0) ##1 (!skipNextOut || $past(instr.valid)))
        else $error("Digit increment or its skip is wrong.");

    a_dec_skip: assert property (pastValid && instr.valid && instr.op == TRX_OP_DEC_DIGIT
        |=> digitPtrOut == 4'($past(digitPtrOut) - 4'h1)
        && skipNextOut == (digitPtrOut == 4'hF))
        else $error("Digit decrement or its skip is wrong.");

    a_ram_read: assert property (pastValid && instr.valid && instr.op == TRX_OP_RAM_READ
        |=> accOut == $past(addressedRamNibble)
        && filePtrOut == ($past(filePtrOut) ^ $past(instr.immFirst)))
        else $error("RAM read or file pointer update is wrong.");

    a_ram_swap: assert property (pastValid && instr.valid && instr.op == TRX_OP_XCHG_DEC
        |=> accOut == $past(addressedRamNibble) && ramMem[$past(ramPointer)] == $past(accOut)
        && skipNextOut == (digitPtrOut == 4'hF))
        else $error("Exchange with decrement is wrong.");

    a_swap_inc: assert property (pastValid && instr.valid && instr.op == TRX_OP_XCHG_INC
        |=> digitPtrOut == 4'($past(digitPtrOut) + 4'h1)
        && filePtrOut == ($past(filePtrOut) ^ $past(instr.immFirst)))
        else $error("Exchange with increment is wrong.");

    a_ram_write: assert property (pastValid && instr.valid && instr.op == TRX_OP_RAM_WRITE
        |=> ramMem[$past(ramPointer)] == $past(accOut) && accOut == $past(accOut))
        else $error("RAM write is wrong.");

    a_ram_xchg: assert property (pastValid && instr.valid && instr.op == TRX_OP_RAM_XCHG
        |=> accOut == $past(addressedRamNibble) && ramMem[$past(ramPointer)] == $past(accOut)
        && filePtrOut == ($past(filePtrOut) ^ $past(instr.immFirst)))
        else $error("RAM exchange is wrong.");

    a_ptr_load: assert property (pastValid && instr.valid && instr.op == TRX_OP_LOAD_PTRS
        && !stateReg.prevLoadPtrs |=> filePtrOut == $past(instr.immFirst)
        && digitPtrOut == $past(instr.immSecond))
        else $error("Pointer load from immediates is wrong.");

    a_xchg_dec_ptrs: assert property (pastValid && instr.valid && instr.op == TRX_OP_XCHG_DEC
        |=> digitPtrOut == 4'($past(digitPtrOut) - 4'h1)
        && filePtrOut == ($past(filePtrOut) ^ $past(instr.immFirst)))
        else $error("Exchange with decrement pointer update is wrong.");

    a_swap_inc_ram: assert property (pastValid && instr.valid && instr.op == TRX_OP_XCHG_INC
        |=> accOut == $past(addressedRamNibble) && ramMem[$past(ramPointer)] == $past(accOut)
        && skipNextOut == (digitPtrOut == 4'h0))
        else $error("Exchange with increment data or skip is wrong.");

    a_idle_hold: assert property (pastValid && !instr.valid
        |=> accOut == $past(accOut) && filePtrOut == $past(filePtrOut)
        && digitPtrOut == $past(digitPtrOut) && !skipNextOut)
        else $error("State changed without an operation.");

    a_none_hold: assert property (pastValid && instr.valid && instr.op == TRX_OP_NONE
        |=> accOut == $past(accOut) && pairOut == $past(pairOut) && bankOut == $past(bankOut)
        && pageOut == $past(pageOut) && !skipNextOut)
        else $error("Empty operation changed state.");

    c_ptr_chain: cover property (instr.valid && instr.op == TRX_OP_LOAD_PTRS
        ##1 instr.valid && instr.op == TRX_OP_LOAD_PTRS);
    c_inc_wrap: cover property (instr.valid && instr.op == TRX_OP_INC_DIGIT ##1 skipNextOut);
    c_dec_wrap: cover property (instr.valid && instr.op == TRX_OP_XCHG_DEC ##1 skipNextOut);
    c_xinc_wrap: cover property (instr.valid && instr.op == TRX_OP_XCHG_INC ##1 skipNextOut);
    c_write_read: cover property (instr.valid && instr.op == TRX_OP_RAM_WRITE
        ##1 instr.valid && instr.op == TRX_OP_RAM_READ);

endmodule

// file: trx_pkg.sv
/*
 * Shared types and constants for the transfer and RAM-address execution unit.
 * Assumes the core sequencer presents one decoded operation per cycle.
 */
package trx_pkg;

    localparam int TRX_NIB_W = 4;
    localparam int TRX_PAGE_W = 3;
    localparam int TRX_BANK_W = 2;
    localparam int TRX_SP_W = 3;
    localparam int TRX_PAIR_W = 8;
    localparam int TRX_PAIR_HI_POS = 4;
    localparam int TRX_RAM_AW = TRX_BANK_W + 2 * TRX_NIB_W;

    localparam logic [3:0] TRX_ACC_RST = 4'h0;
    localparam logic [3:0] TRX_NIB_RST = 4'h0;
    localparam logic [7:0] TRX_PAIR_RST = 8'h00;
    localparam logic [2:0] TRX_PAGE_RST = 3'h0;
    localparam logic [1:0] TRX_BANK_RST = 2'h0;
    localparam logic [3:0] TRX_DIGIT_WRAP_UP = 4'h0;
    localparam logic [3:0] TRX_DIGIT_WRAP_DN = 4'hF;

    typedef enum logic [4:0] {
        TRX_OP_NONE = 5'h00,
        TRX_OP_B_TO_A = 5'h01,
        TRX_OP_A_TO_B = 5'h02,
        TRX_OP_DIGIT_TO_A = 5'h03,
        TRX_OP_A_TO_DIGIT = 5'h04,
        TRX_OP_PACK = 5'h05,
        TRX_OP_UNPACK = 5'h06,
        TRX_OP_A_TO_PAGE = 5'h07,
        TRX_OP_PAGE_TO_A = 5'h08,
        TRX_OP_BANK_TO_A = 5'h09,
        TRX_OP_FILE_TO_A = 5'h0A,
        TRX_OP_SP_TO_A = 5'h0B,
        TRX_OP_LOAD_PTRS = 5'h0C,
        TRX_OP_LOAD_BANK = 5'h0D,
        TRX_OP_INC_DIGIT = 5'h0E,
        TRX_OP_DEC_DIGIT = 5'h0F,
        TRX_OP_RAM_READ = 5'h10,
        TRX_OP_RAM_XCHG = 5'h11,
        TRX_OP_XCHG_DEC = 5'h12,
        TRX_OP_XCHG_INC = 5'h13,
        TRX_OP_RAM_WRITE = 5'h14
    } trx_op_type;

    typedef struct packed {
        logic valid;
        trx_op_type op;
        logic [3:0] immFirst;
        logic [3:0] immSecond;
    } trx_instr_type;

    typedef struct packed {
        logic [3:0] acc;
        logic [3:0] accB;
        logic [7:0] pair;
        logic [2:0] page;
        logic [1:0] bank;
        logic [3:0] filePtr;
        logic [3:0] digitPtr;
        logic skipNext;
        logic prevLoadPtrs;
    } trx_state_type;

endpackage

// file: trx_exec_tb.sv
/*
 * Self-checking testbench for the transfer and RAM-address execution unit.
 * Assumes the unit answers one cycle after each taken operation and that
 * its own assertions watch the port timing.
 */
module trx_exec_tb
    import trx_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk;
    logic sysRst;
    trx_instr_type instr;
    logic [2:0] stackPtr;
    logic [3:0] accOut, accBOut, fileOut, digitOut;
    logic [7:0] pairOut;
    logic [2:0] pageOut;
    logic [1:0] bankOut;
    logic skipOut;
    logic [3:0] ma, mb, mx, my;
    logic [7:0] me;
    logic [2:0] md;
    logic [1:0] mz;
    logic sk, chain;
    logic [3:0] mem [int];
    int n_fail = 0;
    int total_checks = 0;

    trx_exec uut (
        .clk(clk),
        .sys_rst(sysRst),
        .instr(instr),
        .stack_pointer(stackPtr),
        .accOut(accOut),
        .accBOut(accBOut),
        .pairOut(pairOut),
        .pageOut(pageOut),
        .bankOut(bankOut),
        .filePtrOut(fileOut),
        .digitPtrOut(digitOut),
        .skipNextOut(skipOut)
    );

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic cmp_all();
        check("acc", {4'h0, accOut}, {4'h0, ma});
        check("accB", {4'h0, accBOut}, {4'h0, mb});
        check("pair", pairOut, me);
        check("page", {5'h00, pageOut}, {5'h00, md});
        check("bank", {6'h00, bankOut}, {6'h00, mz});
        check("file", {4'h0, fileOut}, {4'h0, mx});
        check("digit", {4'h0, digitOut}, {4'h0, my});
        check("skip", {7'h00, skipOut}, {7'h00, sk});
    endtask

    task automatic step(input trx_op_type op, input logic [3:0] f, input logic [3:0] s);
        logic [9:0] ad;
        logic [3:0] t;
        instr = '{valid: 1'b1, op: op, immFirst: f, immSecond: s};
        ad = {mz, mx, my};
        sk = 1'b0;
        case (op)
            TRX_OP_B_TO_A: ma = mb;
            TRX_OP_A_TO_B: mb = ma;
            TRX_OP_DIGIT_TO_A: ma = my;
            TRX_OP_A_TO_DIGIT: my = ma;
            TRX_OP_PACK: me = {mb, ma};
            TRX_OP_UNPACK: {mb, ma} = me;
            TRX_OP_A_TO_PAGE: md = ma[2:0];
            TRX_OP_PAGE_TO_A: ma = {1'b0, md};
            TRX_OP_BANK_TO_A: ma = {2'b00, mz};
            TRX_OP_FILE_TO_A: ma = mx;
            TRX_OP_SP_TO_A: ma = {1'b0, stackPtr};
            TRX_OP_LOAD_PTRS: if (!chain) begin
                mx = f;
                my = s;
            end
            TRX_OP_LOAD_BANK: mz = f[1:0];
            TRX_OP_INC_DIGIT: begin
                my = my + 4'h1;
                sk = (my == 4'h0);
            end
            TRX_OP_DEC_DIGIT: begin
                my = my - 4'h1;
                sk = (my == 4'hF);
            end
            TRX_OP_RAM_READ: begin
                ma = mem[ad];
                mx = mx ^ f;
            end
            TRX_OP_RAM_XCHG, TRX_OP_XCHG_DEC, TRX_OP_XCHG_INC: begin
                t = mem[ad];
                mem[ad] = ma;
                ma = t;
                mx = mx ^ f;
                if (op == TRX_OP_XCHG_DEC) begin
                    my = my - 4'h1;
                    sk = (my == 4'hF);
                end
                if (op == TRX_OP_XCHG_INC) begin
                    my = my + 4'h1;
                    sk = (my == 4'h0);
                end
            end
            TRX_OP_RAM_WRITE: begin
                mem[ad] = ma;
                mx = mx ^ f;
            end
            default: ;
        endcase
        chain = (op == TRX_OP_LOAD_PTRS);
        @(posedge clk);
        #1;
        cmp_all();
    endtask

    task automatic idle();
        instr = '0;
        sk = 1'b0;
        @(posedge clk);
        #1;
        cmp_all();
    endtask

    task automatic sc_transfers();
        stackPtr = 3'h5;
        step(TRX_OP_LOAD_PTRS, 4'hA, 4'h5);
        step(TRX_OP_FILE_TO_A, 4'h0, 4'h0);
        step(TRX_OP_A_TO_B, 4'h0, 4'h0);
        step(TRX_OP_DIGIT_TO_A, 4'h0, 4'h0);
        step(TRX_OP_PACK, 4'h0, 4'h0);
        step(TRX_OP_LOAD_BANK, 4'hE, 4'h0);
        step(TRX_OP_BANK_TO_A, 4'h0, 4'h0);
        step(TRX_OP_UNPACK, 4'h0, 4'h0);
        step(TRX_OP_LOAD_PTRS, 4'hF, 4'hC);
        step(TRX_OP_FILE_TO_A, 4'h0, 4'h0);
        step(TRX_OP_A_TO_PAGE, 4'h0, 4'h0);
        step(TRX_OP_A_TO_DIGIT, 4'h0, 4'h0);
        step(TRX_OP_SP_TO_A, 4'h0, 4'h0);
        step(TRX_OP_B_TO_A, 4'h0, 4'h0);
        step(TRX_OP_PAGE_TO_A, 4'h0, 4'h0);
        step(TRX_OP_NONE, 4'h3, 4'h3);
        idle();
    endtask

    task automatic sc_chain();
        step(TRX_OP_LOAD_PTRS, 4'h1, 4'h2);
        step(TRX_OP_LOAD_PTRS, 4'h3, 4'h4);
        idle();
        step(TRX_OP_LOAD_PTRS, 4'h5, 4'h6);
        step(TRX_OP_FILE_TO_A, 4'h0, 4'h0);
        step(TRX_OP_LOAD_PTRS, 4'h7, 4'h8);
        idle();
    endtask

    task automatic sc_skip();
        step(TRX_OP_NONE, 4'h0, 4'h0);
        step(TRX_OP_LOAD_PTRS, 4'h2, 4'hF);
        step(TRX_OP_INC_DIGIT, 4'h0, 4'h0);
        idle();
        step(TRX_OP_DEC_DIGIT, 4'h0, 4'h0);
        idle();
        step(TRX_OP_DEC_DIGIT, 4'h0, 4'h0);
        step(TRX_OP_INC_DIGIT, 4'h0, 4'h0);
        idle();
    endtask

    task automatic sc_reset();
        sysRst = 1'b1;
        instr = '{valid: 1'b1, op: TRX_OP_LOAD_PTRS, immFirst: 4'h5, immSecond: 4'h6};
        {ma, mb, mx, my, me, md, mz, sk, chain} = '0;
        @(posedge clk);
        #1;
        instr = '0;
        @(posedge clk);
        #1;
        sysRst = 1'b0;
        cmp_all();
    endtask

    task automatic sc_ram();
        step(TRX_OP_LOAD_BANK, 4'h3, 4'h0);
        step(TRX_OP_LOAD_PTRS, 4'h9, 4'hF);
        step(TRX_OP_FILE_TO_A, 4'h0, 4'h0);
        step(TRX_OP_RAM_WRITE, 4'h0, 4'h0);
        step(TRX_OP_RAM_READ, 4'h0, 4'h0);
        step(TRX_OP_UNPACK, 4'h0, 4'h0);
        step(TRX_OP_XCHG_INC, 4'h6, 4'h0);
        idle();
        step(TRX_OP_RAM_WRITE, 4'h0, 4'h0);
        step(TRX_OP_DIGIT_TO_A, 4'h0, 4'h0);
        step(TRX_OP_XCHG_DEC, 4'h6, 4'h0);
        idle();
        step(TRX_OP_RAM_XCHG, 4'h0, 4'h0);
        step(TRX_OP_RAM_READ, 4'h5, 4'h0);
        idle();
    endtask

    initial begin
        sysRst = 1'b1;
        instr = '0;
        stackPtr = 3'h0;
        {ma, mb, mx, my, me, md, mz, sk, chain} = '0;
        repeat (10) @(posedge clk);
        #1;
        sysRst = 1'b0;
        cmp_all();
        sc_transfers();
        sc_chain();
        sc_skip();
        sc_reset();
        sc_ram();
        complete_run();
    end

    initial begin
        #5000000;
        n_fail++;
        complete_run();
    end
endmodule
